// file: hw/mcc_pkg.sv
// Purpose: shared constants and types of the monitor conversion control
// Assumes: 100 MHz reference clock, 16-bit registers behind a two-wire port
// Notes:   times are kept in ns, cycle counts are derived from the clock period
package mcc_pkg;
  localparam int unsigned CLK_NS = 10;
  localparam logic [7:0] PTR_CFG = 8'h00;
  localparam logic [7:0] PTR_SENSE = 8'h01;
  localparam logic [7:0] PTR_RAIL = 8'h02;
  localparam logic [7:0] PTR_POWER = 8'h03;
  localparam logic [15:0] CFG_RST = 16'h4127;
  // Bits 14:12 are fixed and read back as their reset value
  localparam logic [2:0] CFG_FIXED = 3'h4;
  localparam int unsigned RST_BIT = 15;
  localparam logic [6:0] DEV_ADDR_DEF = 7'h40;
  localparam int unsigned CUR_SHIFT = 11;
  // Power counts: |current| * rail / 20000, done as a multiply by 2^30/20000
  localparam logic [15:0] PWR_RECIP = 16'hd1b7;
  localparam int unsigned PWR_SHIFT = 30;
  localparam logic [1:0] SYNC_RST = 2'h3;
  localparam int unsigned CONV_NS [8] = '{140000, 204000, 332000, 588000,
                                          1100000, 2116000, 4156000, 8244000};

  typedef logic [7:0][19:0] mcc_cyc_t;

  typedef struct packed {
    logic       rst;
    logic [2:0] fixed;
    logic [2:0] sample_count_sel;
    logic [2:0] rail_conv_time;
    logic [2:0] sense_conv_time;
    logic [2:0] mode;
  } mcc_cfg_t;

  typedef enum logic [2:0] {
    BS_IDLE = 3'h0, BS_ADDR = 3'h1, BS_ACKA = 3'h3, BS_WDATA = 3'h2,
    BS_ACKW = 3'h6, BS_RDATA = 3'h7, BS_ACKR = 3'h5
  } mcc_bus_st_t;

  typedef enum logic [2:0] {
    CV_IDLE = 3'h0, CV_SENSE = 3'h1, CV_RAIL = 3'h3, CV_AVG = 3'h2, CV_MATH = 3'h6
  } mcc_cv_st_t;

  typedef struct packed {
    mcc_cfg_t           cfg;
    mcc_cv_st_t         st;
    logic               armed;
    logic [19:0]        timer;
    logic [10:0]        cnt;
    logic signed [25:0] sense_acc;
    logic [25:0]        rail_acc;
    logic               rail_seen;
    logic [15:0]        sense_res;
    logic [15:0]        rail_res;
    logic [15:0]        power_res;
    logic               done;
    logic               ovf;
  } mcc_meas_t;

  typedef struct packed {
    mcc_bus_st_t st;
    logic [3:0]  bitcnt;
    logic [7:0]  shreg;
    logic        rw;
    logic [7:0]  ptr;
    logic [1:0]  bytecnt;
    logic [7:0]  wmsb;
    logic [15:0] rdword;
    logic        rdlsb;
    logic        nack;
    logic        sda_drv;
    logic        sda_lvl;
    logic        halt;
    logic        scl_q;
    logic        sda_q;
  } mcc_bus_t;

  typedef struct packed {
    mcc_bus_t  bus;
    mcc_meas_t meas;
  } mcc_state_t;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] q;
  } mcc_sync_t;

  localparam mcc_meas_t MEAS_RST = mcc_meas_t'({CFG_RST, {($bits(mcc_meas_t) - 16){1'b0}}});

  function automatic mcc_cyc_t conv_cycles();
    for (int i = 0; i < 8; i++) begin
      conv_cycles[i] = 20'((CONV_NS[i] + CLK_NS - 1) / CLK_NS);
    end
  endfunction

  function automatic logic [10:0] avg_samples(logic [2:0] code);
    case (code)
      3'h0: avg_samples = 11'h001;
      3'h1: avg_samples = 11'h004;
      3'h2: avg_samples = 11'h010;
      3'h3: avg_samples = 11'h040;
      3'h4: avg_samples = 11'h080;
      3'h5: avg_samples = 11'h100;
      3'h6: avg_samples = 11'h200;
      default: avg_samples = 11'h400;
    endcase
  endfunction

  function automatic logic sel_sense(logic [2:0] m);
    sel_sense = m[0];
  endfunction

  function automatic logic sel_rail(logic [2:0] m);
    sel_rail = m[1];
  endfunction

  function automatic logic powered_down(logic [2:0] m);
    powered_down = (m[1:0] == 2'h0);
  endfunction
endpackage

// file: hw/mcc_pin_sync.sv
// Purpose: filters the two-wire port pins into the reference clock domain
// Assumes: idle bus level is high on both pins
// Notes:   a level is taken once the second and third stage agree
`timescale 1ns/10ps
`default_nettype none
module mcc_pin_sync (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic [1:0] pin_in,
  output var  logic [1:0] pin_out
);
  import mcc_pkg::*;
  mcc_sync_t st;
  mcc_sync_t next_st;
  logic [1:0] agree;

  always_comb begin
    agree = ~(st.s2 ^ st.s3);
    next_st.s1 = pin_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.q = (agree & st.s2) | (~agree & st.q);
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= {SYNC_RST, SYNC_RST, SYNC_RST, SYNC_RST};
    end else begin
      st <= next_st;
    end
  end

  assign pin_out = st.q;
endmodule
`default_nettype wire

// file: hw/mcc_math.sv
// Purpose: current and power arithmetic behind the result registers
// Assumes: inputs are held stable for the cycle in which results are taken
// Notes:   results saturate when a step overflows
`timescale 1ns/10ps
`default_nettype none
module mcc_math (
  input  wire logic signed [15:0] sense,
  input  wire logic [15:0]        rail,
  input  wire logic [14:0]        cal,
  output var  logic [15:0]        power,
  output var  logic               overflow
);
  import mcc_pkg::*;
  logic signed [31:0] prod;
  logic signed [31:0] cur;
  logic [15:0]        cur_sat;
  logic [15:0]        mag;
  logic [46:0]        raw;
  logic               cur_ovf;

  always_comb begin
    prod = sense * $signed({1'b0, cal});
    cur = prod >>> CUR_SHIFT;
    cur_ovf = (cur > 32'sd32767) || (cur < -32'sd32768);
    cur_sat = cur_ovf ? (cur[31] ? 16'h8000 : 16'h7fff) : cur[15:0];
    mag = cur_sat[15] ? 16'(-cur_sat) : cur_sat;
    raw = 47'(47'(mag) * 47'(rail[14:0]) * 47'(PWR_RECIP)) >> PWR_SHIFT;
    overflow = cur_ovf || (raw[46:16] != 31'h0);
    power = overflow ? 16'hffff : raw[15:0];
  end
endmodule
`default_nettype wire

// file: hw/mcc_monitor_ctrl.sv
// Purpose: conversion control and result registers of a current and power monitor
// Assumes: samples arrive on the reference clock; calibration is a plain input
// Notes:   registers are reached over the two-wire port as 16-bit words, MSB first
//
// Contract
// - Reading the configuration changes no setting and no running measurement.
// - A configuration write holds conversion, then restarts with new settings.
// - Writing bit 15 resets everything to defaults; the bit self-clears.
// - Bits 11:9 pick 1, 4, 16, 64, 128, 256, 512 or 1024 samples.
// - Bits 8:6 set rail conversion time, 140us up to 8.244ms.
// - Bits 5:3 set sense conversion time with the same eight steps.
// - Mode 0/4 power-down; 1-3 triggered; 5-7 continuous sense, rail, both.
// - Reset gives continuous both, one sample, 1.1ms on both channels.
// - Sense result is two's complement; MSB set means negative.
// - Sense count weighs 2.5uV; 7FFF is 81.92mV.
// - Rail result holds latest reading; count 1.25mV, 7FFF is 40.96V.
// - Rail result bit 15 always reads zero.
// - With averaging, sense, rail and power hold averaged values.
// - One power count equals 25 current steps.
// - Power is current times rail voltage.
// - Current is sense result times calibration.
// - Done flag sets after math; cleared by non-power-down write or mask read.
// - Overflow flag marks an arithmetic overflow in current or power.
`timescale 1ns/10ps
`default_nettype none
module mcc_monitor_ctrl #(
  parameter mcc_pkg::mcc_cyc_t CONV_CYC = mcc_pkg::conv_cycles(),
  parameter logic [6:0]        DEV_ADDR = mcc_pkg::DEV_ADDR_DEF
) (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output var  logic        sda_out,
  output var  logic        sda_oe,
  input  wire logic [15:0] sense_sample,
  input  wire logic [15:0] rail_sample,
  input  wire logic [14:0] cal_value,
  input  wire logic        mask_read,
  output var  logic        conversion_done_flag,
  output var  logic        math_overflow_flag
);
  import mcc_pkg::*;

  localparam mcc_state_t ST_RST = '{bus: mcc_bus_t'(2'h3), meas: MEAS_RST};  // Edge detect idles high

  mcc_state_t  st;
  mcc_state_t  next_st;
  mcc_cfg_t    c;
  logic [1:0]  pins;
  logic [15:0] pwr_val;
  logic        math_ovf;
  logic        scl;
  logic        sda;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic        cfg_wr;
  logic [15:0] wword;
  logic [15:0] rword;
  logic [7:0]  rbyte;
  logic        first_rail;
  logic [19:0] first_tm;
  logic [3:0]  sh;

  mcc_pin_sync u_sync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .pin_in  ({scl_in, sda_in}),
    .pin_out (pins)
  );

  mcc_math u_math (
    .sense    (st.meas.sense_res),
    .rail     (st.meas.rail_res),
    .cal      (cal_value),
    .power    (pwr_val),
    .overflow (math_ovf)
  );

  // Reads are side-effect free; unmapped pointers return zero
  function automatic logic [15:0] reg_read(logic [7:0] ptr, mcc_meas_t m);
    case (ptr)
      PTR_CFG:   reg_read = m.cfg;
      PTR_SENSE: reg_read = m.sense_res;
      PTR_RAIL:  reg_read = m.rail_res;
      PTR_POWER: reg_read = m.power_res;
      default:   reg_read = 16'h0000;
    endcase
  endfunction

  function automatic logic [3:0] avg_shift(logic [2:0] code);
    case (code)
      3'h0: avg_shift = 4'h0;
      3'h1: avg_shift = 4'h2;
      3'h2: avg_shift = 4'h4;
      3'h3: avg_shift = 4'h6;
      3'h4: avg_shift = 4'h7;
      3'h5: avg_shift = 4'h8;
      3'h6: avg_shift = 4'h9;
      default: avg_shift = 4'ha;
    endcase
  endfunction

  always_comb begin
    scl      = pins[1];
    sda      = pins[0];
    scl_rise = scl & ~st.bus.scl_q;
    scl_fall = ~scl & st.bus.scl_q;
    start_c  = scl & st.bus.scl_q & st.bus.sda_q & ~sda;
    stop_c   = scl & st.bus.scl_q & ~st.bus.sda_q & sda;
    wword    = {st.bus.wmsb, st.bus.shreg};
    cfg_wr   = 1'b0;
    rword    = reg_read(st.bus.ptr, st.meas);
    rbyte    = st.bus.rdlsb ? rword[15:8] : st.bus.rdword[7:0];
    c        = st.meas.cfg;
    sh       = avg_shift(c.sample_count_sel);
    first_rail = !sel_sense(c.mode);
    first_tm = CONV_CYC[first_rail ? c.rail_conv_time : c.sense_conv_time] - 20'd1;
    next_st  = st;
    next_st.bus.scl_q = scl;
    next_st.bus.sda_q = sda;

    // Serial port: a start or stop wins over any bit in flight
    if (start_c) begin
      next_st.bus.st = BS_ADDR;
      next_st.bus.bitcnt = 4'h0;
      next_st.bus.sda_drv = 1'b0;
      next_st.bus.halt = 1'b0;
    end else if (stop_c) begin
      next_st.bus.st = BS_IDLE;
      next_st.bus.sda_drv = 1'b0;
      next_st.bus.halt = 1'b0;
    end else begin
      case (st.bus.st)
        BS_ADDR, BS_WDATA: begin
          if (scl_rise) begin
            next_st.bus.shreg = {st.bus.shreg[6:0], sda};
            next_st.bus.bitcnt = st.bus.bitcnt + 4'h1;
          end else if (scl_fall && st.bus.bitcnt == 4'h8) begin
            next_st.bus.bitcnt = 4'h0;
            if (st.bus.st == BS_ADDR) begin
              if (st.bus.shreg[7:1] == DEV_ADDR) begin
                next_st.bus.st = BS_ACKA;
                next_st.bus.sda_drv = 1'b1;
                next_st.bus.rw = st.bus.shreg[0];
              end else begin
                next_st.bus.st = BS_IDLE;
              end
            end else begin
              next_st.bus.st = BS_ACKW;
              next_st.bus.sda_drv = 1'b1;
              case (st.bus.bytecnt)
                2'h0: begin
                  next_st.bus.ptr = st.bus.shreg;
                  next_st.bus.bytecnt = 2'h1;
                end
                2'h1: begin
                  next_st.bus.wmsb = st.bus.shreg;
                  next_st.bus.halt = (st.bus.ptr == PTR_CFG);
                  next_st.bus.bytecnt = 2'h2;
                end
                default: begin
                  // Further bytes form the next word to the same register
                  cfg_wr = (st.bus.ptr == PTR_CFG);
                  next_st.bus.halt = 1'b0;
                  next_st.bus.bytecnt = 2'h1;
                end
              endcase
            end
          end
        end
        BS_ACKA: begin
          if (scl_fall) begin
            if (st.bus.rw) begin
              next_st.bus.rdword = rword;
              next_st.bus.shreg = rword[15:8];
              next_st.bus.sda_drv = ~rword[15];
              next_st.bus.rdlsb = 1'b0;
              next_st.bus.bitcnt = 4'h1;
              next_st.bus.st = BS_RDATA;
            end else begin
              next_st.bus.sda_drv = 1'b0;
              next_st.bus.bytecnt = 2'h0;
              next_st.bus.st = BS_WDATA;
            end
          end
        end
        BS_ACKW: begin
          if (scl_fall) begin
            next_st.bus.sda_drv = 1'b0;
            next_st.bus.st = BS_WDATA;
          end
        end
        BS_RDATA: begin
          if (scl_fall) begin
            if (st.bus.bitcnt == 4'h8) begin
              next_st.bus.sda_drv = 1'b0;
              next_st.bus.st = BS_ACKR;
            end else begin
              next_st.bus.shreg = {st.bus.shreg[6:0], 1'b0};
              next_st.bus.sda_drv = ~st.bus.shreg[6];
              next_st.bus.bitcnt = st.bus.bitcnt + 4'h1;
            end
          end
        end
        BS_ACKR: begin
          if (scl_rise) begin
            next_st.bus.nack = sda;
          end else if (scl_fall) begin
            if (st.bus.nack) begin
              next_st.bus.st = BS_IDLE;
            end else begin
              // Word is re-sampled only at its MSB so both bytes match
              if (st.bus.rdlsb) begin
                next_st.bus.rdword = rword;
              end
              next_st.bus.rdlsb = ~st.bus.rdlsb;
              next_st.bus.shreg = rbyte;
              next_st.bus.sda_drv = ~rbyte[7];
              next_st.bus.bitcnt = 4'h1;
              next_st.bus.st = BS_RDATA;
            end
          end
        end
        default: begin
          next_st.bus.sda_drv = 1'b0;
        end
      endcase
    end

    if (mask_read) begin
      next_st.meas.done = 1'b0;
    end

    if (cfg_wr && wword[RST_BIT]) begin
      next_st.meas = MEAS_RST;
    end else if (cfg_wr) begin
      next_st.meas.cfg = mcc_cfg_t'({1'b0, CFG_FIXED, wword[11:0]});
      next_st.meas.st = CV_IDLE;
      next_st.meas.armed = 1'b1;
      if (!powered_down(wword[2:0])) begin
        next_st.meas.done = 1'b0;
      end
    end else if (!st.bus.halt) begin
      case (st.meas.st)
        CV_IDLE: begin
          if (!powered_down(c.mode) && (c.mode[2] || st.meas.armed)) begin
            next_st.meas.armed = 1'b0;
            next_st.meas.cnt = 11'h000;
            next_st.meas.sense_acc = 26'sh0;
            next_st.meas.rail_acc = 26'h0;
            next_st.meas.rail_seen = 1'b0;
            next_st.meas.timer = first_tm;
            next_st.meas.st = first_rail ? CV_RAIL : CV_SENSE;
          end
        end
        CV_SENSE: begin
          if (st.meas.timer != 20'h0) begin
            next_st.meas.timer = st.meas.timer - 20'h1;
          end else begin
            next_st.meas.sense_acc = st.meas.sense_acc + {{10{sense_sample[15]}}, sense_sample};
            if (sel_rail(c.mode)) begin
              next_st.meas.timer = CONV_CYC[c.rail_conv_time] - 20'd1;
              next_st.meas.st = CV_RAIL;
            end else begin
              next_st.meas.st = CV_AVG;
            end
          end
        end
        CV_RAIL: begin
          if (st.meas.timer != 20'h0) begin
            next_st.meas.timer = st.meas.timer - 20'h1;
          end else begin
            // sign bit of the rail sample is dropped
            next_st.meas.rail_acc = st.meas.rail_acc + 26'(rail_sample[14:0]);
            next_st.meas.rail_seen = 1'b1;
            next_st.meas.st = CV_AVG;
          end
        end
        CV_AVG: begin
          if (st.meas.cnt == avg_samples(c.sample_count_sel) - 11'd1) begin
            if (sel_sense(c.mode)) begin
              next_st.meas.sense_res = 16'(st.meas.sense_acc >>> sh);
            end
            if (st.meas.rail_seen) begin
              next_st.meas.rail_res = {1'b0, 15'(st.meas.rail_acc >> sh)};
            end
            next_st.meas.st = CV_MATH;
          end else begin
            next_st.meas.cnt = st.meas.cnt + 11'd1;
            next_st.meas.timer = first_tm;
            next_st.meas.st = first_rail ? CV_RAIL : CV_SENSE;
          end
        end
        CV_MATH: begin
          // power only after a rail reading
          if (st.meas.rail_seen) begin
            next_st.meas.power_res = pwr_val;
          end
          next_st.meas.ovf = math_ovf;
          next_st.meas.done = 1'b1;
          next_st.meas.st = CV_IDLE;
        end
        default: begin
          next_st.meas.st = CV_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // Open-drain: the data level is always low, only the enable moves
  assign sda_out = st.bus.sda_lvl;
  assign sda_oe = st.bus.sda_drv;
  assign conversion_done_flag = st.meas.done;
  assign math_overflow_flag = st.meas.ovf;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_cfg_stable:
    assert property (!cfg_wr |=> $stable(st.meas.cfg))
    else $error("config changed without a write");
  chk_write_restart:
    assert property (cfg_wr && !wword[RST_BIT] && !powered_down(wword[2:0])
                     |=> st.meas.st == CV_IDLE ##1 st.meas.st inside {CV_SENSE, CV_RAIL})
    else $error("config write did not restart conversion");
  chk_halt_freeze:
    assert property (st.bus.halt && !cfg_wr |=> $stable(st.meas.timer) && $stable(st.meas.st))
    else $error("conversion moved during config write");
  chk_soft_reset:
    assert property (cfg_wr && wword[RST_BIT] |=> st.meas.cfg == CFG_RST && !st.meas.done)
    else $error("soft reset did not restore defaults");
  chk_avg_count:
    assert property (st.meas.st == CV_MATH |-> $past(st.meas.cnt) == avg_samples(c.sample_count_sel) - 11'd1)
    else $error("wrong number of samples averaged");
  chk_rail_time:
    assert property ($changed(st.meas.st) && st.meas.st == CV_RAIL
                     |-> st.meas.timer == CONV_CYC[c.rail_conv_time] - 20'd1)
    else $error("rail conversion time wrong");
  chk_sense_time:
    assert property ($changed(st.meas.st) && st.meas.st == CV_SENSE
                     |-> st.meas.timer == CONV_CYC[c.sense_conv_time] - 20'd1)
    else $error("sense conversion time wrong");
  chk_pd_idle:
    assert property (powered_down(c.mode) && st.meas.st == CV_IDLE && !cfg_wr |=> st.meas.st == CV_IDLE)
    else $error("conversion started in power-down");
  chk_rail_msb:
    assert property (st.meas.rail_res[15] == 1'b0)
    else $error("rail result sign bit set");
  chk_done_set:
    assert property (st.meas.st == CV_MATH && !st.bus.halt |=> st.meas.done)
    else $error("done flag not set after math");
  chk_ovf_take:
    assert property (st.meas.st == CV_MATH && !st.bus.halt |=> st.meas.ovf == $past(math_ovf))
    else $error("overflow flag not taken from math");
  chk_trig_once:
    assert property (st.meas.st == CV_MATH && !c.mode[2] && !st.bus.halt
                     |=> st.meas.st == CV_IDLE && !st.meas.armed)
    else $error("triggered mode did not idle");
  chk_power_fresh:
    assert property ($changed(st.meas.power_res) |-> $past(st.meas.rail_seen) || $past(cfg_wr))
    else $error("power updated without rail reading");
endmodule
`default_nettype wire

// file: testbench/mcc_host_model.sv
// Purpose: two-wire bus master for 16-bit register access
// Assumes: open-drain line resolved with a pull-up in the bench
// Notes:   8 clocks a phase, three phases a bit, well past the pin filter delay
`timescale 1ns/10ps
`default_nettype none
module mcc_host_model (
  input  wire logic ref_clk,
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_oe
);
  import mcc_pkg::*;
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic hp();
    repeat (8) @(posedge ref_clk);
  endtask
  // Start and repeated start share one shape
  task automatic start();
    sda_oe <= 1'b0;
    hp();
    scl <= 1'b1;
    hp();
    sda_oe <= 1'b1;
    hp();
    scl <= 1'b0;
    hp();
  endtask
  task automatic stop();
    sda_oe <= 1'b1;
    hp();
    scl <= 1'b1;
    hp();
    sda_oe <= 1'b0;
    hp();
  endtask
  // Data only moves while the clock is low, never at its edges
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx);
    logic [8:0] sh;
    logic [8:0] r;
    sh = {~tx, mack};
    for (int i = 0; i < 9; i++) begin
      sda_oe <= sh[8];
      sh = sh << 1;
      hp();
      scl <= 1'b1;
      hp();
      r = {r[7:0], sda};
      scl <= 1'b0;
      hp();
    end
    rx = r[8:1];
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [15:0] d);
    logic [7:0] x;
    start();
    xfer({DEV_ADDR_DEF, 1'b0}, 1'b0, x);
    xfer(ptr, 1'b0, x);
    xfer(d[15:8], 1'b0, x);
    xfer(d[7:0], 1'b0, x);
    stop();
  endtask
  task automatic rd(input logic [7:0] ptr, output logic [15:0] d);
    start();
    xfer({DEV_ADDR_DEF, 1'b0}, 1'b0, d[7:0]);
    xfer(ptr, 1'b0, d[7:0]);
    start();
    xfer({DEV_ADDR_DEF, 1'b1}, 1'b0, d[7:0]);
    xfer(8'hff, 1'b1, d[15:8]);
    xfer(8'hff, 1'b0, d[7:0]);
    stop();
  endtask
endmodule
`default_nettype wire

// file: testbench/tb_mcc_monitor_ctrl.sv
// Purpose: self-checking bench of the monitor conversion control
// Assumes: conversion times cut to 4..11 clocks
// Notes:   power follows the chosen reciprocal scaling
`timescale 1ns/10ps
`default_nettype none
module tb_mcc_monitor_ctrl;
  import mcc_pkg::*;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        scl;
  logic        host_oe;
  logic        dev_oe;
  logic        dev_lvl;
  logic [15:0] sense_sample = 16'h8300;
  logic [15:0] rail_sample = 16'hffff;
  logic [14:0] cal_value = 15'h0800;
  logic        mask_read = 1'b0;
  logic        done;
  logic        ovf;
  logic [15:0] v;
  int          errors = 0;
  int          checked = 0;
  // Pull-up line: the device shows its driven level only while enabled
  wire         sda = ~host_oe & (~dev_oe | dev_lvl);
  always #5 ref_clk = ~ref_clk;
  mcc_host_model i_mcc_host_model (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_oe(host_oe));
  mcc_monitor_ctrl #(.CONV_CYC({20'd11, 20'd10, 20'd9, 20'd8, 20'd7, 20'd6, 20'd5, 20'd4})) i_mcc_monitor_ctrl (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out(dev_lvl), .sda_oe(dev_oe),
    .sense_sample(sense_sample), .rail_sample(rail_sample), .cal_value(cal_value),
    .mask_read(mask_read), .conversion_done_flag(done), .math_overflow_flag(ovf));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wait_done();
    for (int n = 0; n < 300 && done !== 1'b1; n++)
      @(posedge ref_clk);
    if (done !== 1'b1) begin
      chk({15'h0, done}, 16'h0001);
      results();
    end
  endtask
  function automatic logic [15:0] pexp(logic [15:0] s, logic [15:0] r);
    longint c;
    longint p;
    c = (longint'($signed(s)) * longint'(cal_value)) >>> CUR_SHIFT;
    if (c < 0)
      c = -c;
    p = (c * longint'(r[14:0]) * longint'(PWR_RECIP)) >>> PWR_SHIFT;
    return (p > 65535) ? 16'hffff : p[15:0];
  endfunction
  task automatic t_defaults();
    i_mcc_host_model.rd(PTR_CFG, v);
    chk(v, 16'h4127);
    i_mcc_host_model.rd(PTR_SENSE, v);
    chk(v, 16'h8300);
    i_mcc_host_model.rd(PTR_RAIL, v);
    chk(v, 16'h7fff);
    i_mcc_host_model.rd(PTR_POWER, v);
    chk(v, pexp(16'h8300, 16'h7fff));
    i_mcc_host_model.wr(PTR_SENSE, 16'h1234);
    i_mcc_host_model.rd(PTR_SENSE, v);
    chk(v, 16'h8300);
    i_mcc_host_model.rd(8'h07, v);
    chk(v, 16'h0000);
  endtask
  task automatic t_fields();
    logic [15:0] w;
    for (int i = 0; i < 8; i++) begin
      w = {4'h0, 3'(i), 3'(i), 3'(i), 3'(i)};
      i_mcc_host_model.wr(PTR_CFG, w);
      i_mcc_host_model.rd(PTR_CFG, v);
      chk(v, {4'h4, w[11:0]});
    end
  endtask
  // Order 7, 4, 3, 0 so a power-down write meets a set done flag
  task automatic t_modes();
    logic [2:0] m;
    for (int i = 0; i < 4; i++) begin
      m = 3'(12'h0e7 >> (i * 3));
      i_mcc_host_model.wr(PTR_CFG, {13'h0, m});
      if (m[1:0] != 2'h0)
        wait_done();
      else
        repeat (200) @(posedge ref_clk);
      chk({15'h0, done}, {15'h0, i < 3});
      mask_read <= 1'b1;
      @(posedge ref_clk);
      mask_read <= 1'b0;
      repeat (200) @(posedge ref_clk);
      chk({15'h0, done}, {15'h0, m == 3'h7});
    end
  endtask
  task automatic t_math();
    cal_value <= 15'h7fff;
    sense_sample <= 16'h8000;
    i_mcc_host_model.wr(PTR_CFG, 16'h0003);
    wait_done();
    chk({15'h0, ovf}, 16'h0001);
    cal_value <= 15'h0800;
    sense_sample <= 16'h8300;
    rail_sample <= 16'h0100;
    i_mcc_host_model.wr(PTR_CFG, 16'h0203);
    wait_done();
    chk({15'h0, ovf}, 16'h0000);
    i_mcc_host_model.rd(PTR_POWER, v);
    chk(v, pexp(16'h8300, 16'h0100));
    // New sense word too: a power pass without a rail reading would move the result
    sense_sample <= 16'h4000;
    rail_sample <= 16'h2000;
    i_mcc_host_model.wr(PTR_CFG, 16'h0001);
    wait_done();
    i_mcc_host_model.rd(PTR_POWER, v);
    chk(v, pexp(16'h8300, 16'h0100));
    i_mcc_host_model.rd(PTR_SENSE, v);
    chk(v, 16'h4000);
    i_mcc_host_model.rd(PTR_RAIL, v);
    chk(v, 16'h0100);
    i_mcc_host_model.wr(PTR_CFG, 16'h8000);
    i_mcc_host_model.rd(PTR_CFG, v);
    chk(v, 16'h4127);
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (10) @(posedge ref_clk);
    t_defaults();
    t_fields();
    t_modes();
    t_math();
    results();
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    $display("[FAIL] %0t got %h exp %h", $time, 1'b0, 1'b1);
    errors++;
    results();
  end
endmodule
`default_nettype wire
